// ### src/cla_pkg.sv
// Purpose: Shared constants for the classifier action apply block.
// Assumes: Byte-granular frame pointer of eight bits.
// Notes: Pipeline point codes above 15 are rewriter points.
package cla_pkg;
  localparam int PTR_W = 8;
  localparam int PORT_CNT = 64;
  localparam logic [1:0] ETHERNET_LAYER_TYPE = 2'h0;
  localparam logic [1:0] EXT_CURRENT = 2'h0;
  localparam logic [1:0] EXT_PAYLOAD = 2'h1;
  localparam logic [1:0] EXT_PLUS20 = 2'h2;
  localparam logic [1:0] EXT_PLUS40 = 2'h3;
  localparam logic [7:0] EXT_GAP_20 = 8'h14;
  localparam logic [7:0] EXT_GAP_40 = 8'h28;
  localparam int SEL_BIT = 0;
  localparam int FIRST_BIT = 1;
  localparam int SECOND_BIT = 2;
  localparam logic [1:0] FORCE_NONE = 2'h0;
  localparam logic [1:0] FORCE_EXTRACT = 2'h1;
  localparam logic [1:0] FORCE_INSERT = 2'h2;
  localparam logic [1:0] FORCE_LOOPBACK = 2'h3;
  localparam logic [2:0] ACT_NONE = 3'h0;
  localparam logic [2:0] ACT_EXTRACT = 3'h1;
  localparam logic [2:0] ACT_INSERT = 3'h2;
  localparam logic [2:0] ACT_MASQ_INSERT = 3'h3;
  localparam logic [2:0] ACT_LOOP_QUEUE = 3'h4;
  localparam logic [2:0] ACT_LOOP_ASM = 3'h5;
  localparam logic [3:0] KEY_DEFAULT = 4'h0;
  localparam logic [3:0] KEY_TRI_VLAN = 4'h5;
  localparam logic [3:0] KEY_NORMAL_DST = 4'h8;
  localparam logic [3:0] KEY_FINISHED = 4'hF;
  localparam logic [1:0] LSKIP_NONE = 2'h0;
  localparam logic [1:0] LSKIP_ETH = 2'h1;
  localparam logic [1:0] LSKIP_IP_ETH = 2'h2;
  localparam int QUAD_SHIFT = 2;
  localparam int PAIR_SHIFT = 1;
  localparam logic [7:0] RESET_PAG = 8'h00;
  localparam logic [4:0] PT_NONE = 5'h00;
  localparam logic [4:0] PT_PORT_VOE = 5'h02;
  localparam logic [4:0] PT_CLM = 5'h04;
  localparam logic [4:0] PT_OU_MIP = 5'h06;
  localparam logic [4:0] PT_OU_VOE = 5'h09;
  localparam logic [4:0] PT_IN_VOE = 5'h0B;
  localparam logic [4:0] PT_IN_MIP = 5'h0E;
  localparam logic [4:0] PT_DONE = 5'h0F;
  localparam logic [4:0] PT_REW_IN_VOE = 5'h10;
  localparam logic [4:0] PT_REW_OU_VOE = 5'h11;

  // Widens the three-bit point of the reduced form to the full code space.
  function automatic logic [4:0] cla_short_point(input logic [2:0] code);
    logic [4:0] pt;
    unique case (code)
      3'h0: pt = PT_CLM;
      3'h1: pt = PT_OU_MIP;
      3'h2: pt = PT_IN_MIP;
      3'h3: pt = PT_PORT_VOE;
      3'h4: pt = PT_OU_VOE;
      3'h5: pt = PT_IN_VOE;
      3'h6: pt = PT_REW_IN_VOE;
      3'h7: pt = PT_REW_OU_VOE;
    endcase
    return pt;
  endfunction
endpackage

// ### src/cla_ptr_step.sv
// Purpose: Next frame pointer from layer skip and step offsets.
// Assumes: Layer end positions are supplied by the frame parser.
// Notes: Pure combinational; the caller registers the result.
`timescale 1ns/1ns
module cla_ptr_step
  import cla_pkg::*;
(
  input wire logic [7:0] i_frame_ptr,
  input wire logic [7:0] i_eth_end_ptr,
  input wire logic [7:0] i_ip_end_ptr,
  input wire logic i_is_eth,
  input wire logic i_is_ip,
  input wire logic [1:0] i_layer_skip,
  input wire logic [1:0] i_quad_step,
  input wire logic [4:0] i_pair_step,
  output logic [7:0] o_next_ptr
);
  logic [7:0] base;
  logic [7:0] steps;

  // R18 layer skip first
  always_comb
  begin
    base = i_frame_ptr;
    if (i_layer_skip == LSKIP_ETH && i_is_eth)
    begin
      base = i_eth_end_ptr;
    end
    else if (i_layer_skip == LSKIP_IP_ETH && (i_is_eth || i_is_ip))
    begin
      base = i_ip_end_ptr;
    end
  end

  // R15 R16 quad and pair steps
  assign steps = 8'({i_quad_step, 2'b00}) + 8'({i_pair_step, 1'b0});
  // R17 skipped labels excluded
  assign o_next_ptr = base + steps;
endmodule // cla_ptr_step

// ### src/cla_apply.sv
// Purpose: Applies one classification hit to the frame state.
// Assumes: Previous state and parser positions are stable with i_act_valid.
// Notes: One cycle latency; outputs other than o_valid and o_cpu_tag_valid hold between actions.
`timescale 1ns/1ns
// Contract
// R1 - Select bit 0 picks custom key; bits 1 and 2 enable first and second lookup.
// R2 - Extraction starts at current position, payload, payload plus 20 or 40 bytes.
// R3 - Policy group takes action value where mask set, keeps old bits elsewhere.
// R4 - Policy group starts from a default set per ingress port.
// R5 - Override enabled: logical port value drives logical and header source port.
// R6 - Match tag accompanies every frame sent to the processor.
// R7 - Match tag merged under mask; result feeds header classify result.
// R8 - Force code: none, extract, insert or masquerade, loopback queue or assembler.
// R9 - Full form takes the forced point from a five bit code.
// R10 - Reduced form encodes the forced point in three bits mapped to a subset.
// R11 - Next key kind zero keeps default key; 1 to 14 force a format.
// R12 - Next key kind 15 finishes all remaining lookups.
// R13 - Kind 8 swaps destination MAC and IPv4 into source key fields.
// R14 - Kind 5 picks triple VLAN or indexed variant per lookup setting.
// R15 - Frame pointer advances by quad step times four bytes; the code adds the quad step in the reduced form only.
// R16 - Frame pointer advances by pair step times two bytes.
// R17 - Step offsets never count reserved labels already skipped.
// R18 - Layer skip moves the pointer first, then the step is added.
// R19 - Current position extraction applies only to the Ethernet frame type.
// R20 - Fields absent from the reduced form act as zero.
module cla_apply
  import cla_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_pag_cfg_we,
  input wire logic [5:0] i_pag_cfg_port,
  input wire logic [7:0] i_pag_cfg_value,
  input wire logic [3:0] i_triple_vlan_key_choice,
  input wire logic i_act_valid,
  input wire logic i_act_reduced,
  input wire logic i_first_lookup,
  input wire logic [1:0] i_lookup_idx,
  input wire logic [5:0] i_ingress_port,
  input wire logic [7:0] i_policy_group_prev,
  input wire logic [11:0] i_match_tag_prev,
  input wire logic [5:0] i_logical_port_prev,
  input wire logic [4:0] i_pipeline_point_prev,
  input wire logic [2:0] i_pipeline_action_prev,
  input wire logic [1:0] i_frame_type,
  input wire logic [7:0] i_frame_ptr,
  input wire logic [7:0] i_l2_payload_ptr,
  input wire logic [7:0] i_eth_end_ptr,
  input wire logic [7:0] i_ip_end_ptr,
  input wire logic i_frame_is_ip,
  input wire logic i_to_cpu,
  input wire logic [2:0] i_custom_rule_select,
  input wire logic [1:0] i_custom_extract_point,
  input wire logic [7:0] i_policy_group_override_mask,
  input wire logic [7:0] i_policy_group_value,
  input wire logic i_logical_port_override_en,
  input wire logic [5:0] i_logical_port_value,
  input wire logic [11:0] i_entry_match_tag,
  input wire logic [11:0] i_entry_match_tag_mask,
  input wire logic [1:0] i_pipeline_force_code,
  input wire logic i_pipeline_action_variant,
  input wire logic [4:0] i_pipeline_point,
  input wire logic [2:0] i_pipeline_point_short,
  input wire logic [3:0] i_next_key_kind,
  input wire logic [1:0] i_next_pointer_quad_step,
  input wire logic [4:0] i_next_pointer_pair_step,
  input wire logic [1:0] i_next_pointer_layer_skip,
  output logic o_valid,
  output logic [7:0] o_policy_group,
  output logic [11:0] o_entry_match_tag,
  output logic [11:0] o_header_classify_result,
  output logic o_cpu_tag_valid,
  output logic [5:0] o_logical_port,
  output logic [5:0] o_header_source_port,
  output logic [4:0] o_pipeline_point,
  output logic [2:0] o_pipeline_action,
  output logic [3:0] o_next_key_kind,
  output logic o_tri_vlan_indexed,
  output logic o_key_dst_swap,
  output logic o_lookups_finished,
  output logic [7:0] o_frame_pointer,
  output logic o_custom_key_sel,
  output logic o_custom_first_en,
  output logic o_custom_second_en,
  output logic [7:0] o_custom_extract_ptr,
  output logic o_custom_extract_valid
);
  typedef struct packed {
    logic [PORT_CNT-1:0][7:0] pag_default;
    logic valid;
    logic [7:0] policy_group;
    logic [11:0] match_tag;
    logic cpu_tag_valid;
    logic [5:0] logical_port;
    logic [5:0] src_port;
    logic [4:0] point;
    logic [2:0] action;
    logic [3:0] key_kind;
    logic tri_idx;
    logic dst_swap;
    logic finished;
    logic [7:0] frame_ptr;
    logic custom_sel;
    logic custom_first;
    logic custom_second;
    logic [7:0] ext_ptr;
    logic ext_valid;
  } cla_state_type;

  cla_state_type st;
  cla_state_type next_st;
  logic [2:0] eff_custom;
  logic [7:0] eff_pag_mask;
  logic eff_logical_port_en;
  logic [11:0] eff_tag_mask;
  logic [4:0] eff_pair;
  logic [1:0] eff_quad;
  logic [4:0] eff_point;
  logic [7:0] pag_base;
  logic [7:0] step_ptr;
  logic is_eth;

  // R20 absent fields zeroed, except the quad step, which is zeroed in the full form
  assign eff_custom = i_act_reduced ? 3'h0 : i_custom_rule_select;
  assign eff_pag_mask = i_act_reduced ? 8'h00 : i_policy_group_override_mask;
  assign eff_logical_port_en = i_act_reduced ? 1'b0 : i_logical_port_override_en;
  assign eff_tag_mask = i_act_reduced ? 12'h000 : i_entry_match_tag_mask;
  assign eff_pair = i_act_reduced ? 5'h00 : i_next_pointer_pair_step;
  assign eff_quad = i_act_reduced ? i_next_pointer_quad_step : 2'h0;
  // R9 R10 point width by form
  assign eff_point = i_act_reduced ? cla_short_point(i_pipeline_point_short) : i_pipeline_point;
  // R4 per port default
  assign pag_base = i_first_lookup ? st.pag_default[i_ingress_port] : i_policy_group_prev;
  assign is_eth = (i_frame_type == ETHERNET_LAYER_TYPE);

  cla_ptr_step u_step (
    .i_frame_ptr(i_frame_ptr),
    .i_eth_end_ptr(i_eth_end_ptr),
    .i_ip_end_ptr(i_ip_end_ptr),
    .i_is_eth(is_eth),
    .i_is_ip(i_frame_is_ip),
    .i_layer_skip(i_next_pointer_layer_skip),
    .i_quad_step(eff_quad),
    .i_pair_step(eff_pair),
    .o_next_ptr(step_ptr)
  );

  always_comb
  begin
    next_st = st;
    next_st.valid = i_act_valid;
    next_st.cpu_tag_valid = 1'b0;
    if (i_pag_cfg_we)
    begin
      next_st.pag_default[i_pag_cfg_port] = i_pag_cfg_value;
    end
    if (i_act_valid)
    begin
      // R1 custom key selection
      next_st.custom_sel = eff_custom[SEL_BIT];
      next_st.custom_first = eff_custom[FIRST_BIT];
      next_st.custom_second = eff_custom[SECOND_BIT];
      // R2 R19 extraction start
      next_st.ext_valid = 1'b1;
      unique case (i_act_reduced ? EXT_CURRENT : i_custom_extract_point)
        EXT_CURRENT:
        begin
          next_st.ext_ptr = i_frame_ptr;
          next_st.ext_valid = is_eth;
        end
        EXT_PAYLOAD: next_st.ext_ptr = i_l2_payload_ptr;
        EXT_PLUS20: next_st.ext_ptr = i_l2_payload_ptr + EXT_GAP_20;
        EXT_PLUS40: next_st.ext_ptr = i_l2_payload_ptr + EXT_GAP_40;
      endcase
      // R3 masked policy group merge
      next_st.policy_group = (pag_base & ~eff_pag_mask)
        | (i_policy_group_value & eff_pag_mask);
      // R7 masked match tag merge
      next_st.match_tag = (i_match_tag_prev & ~eff_tag_mask)
        | (i_entry_match_tag & eff_tag_mask);
      // R6 tag with processor copy
      next_st.cpu_tag_valid = i_to_cpu;
      // R5 logical port override
      next_st.logical_port = eff_logical_port_en ? i_logical_port_value : i_logical_port_prev;
      next_st.src_port = next_st.logical_port;
      // R8 pipeline forcing
      next_st.point = i_pipeline_point_prev;
      next_st.action = i_pipeline_action_prev;
      unique case (i_pipeline_force_code)
        FORCE_NONE: next_st.action = i_pipeline_action_prev;
        FORCE_EXTRACT:
        begin
          next_st.point = eff_point;
          next_st.action = ACT_EXTRACT;
        end
        FORCE_INSERT:
        begin
          next_st.point = eff_point;
          next_st.action = i_pipeline_action_variant ? ACT_MASQ_INSERT : ACT_INSERT;
        end
        FORCE_LOOPBACK:
        begin
          next_st.point = eff_point;
          next_st.action = i_pipeline_action_variant ? ACT_LOOP_ASM : ACT_LOOP_QUEUE;
        end
      endcase
      // R11 key kind pass through
      next_st.key_kind = i_next_key_kind;
      // R12 finish lookups
      next_st.finished = (i_next_key_kind == KEY_FINISHED);
      // R13 destination into source fields
      next_st.dst_swap = (i_next_key_kind == KEY_NORMAL_DST);
      // R14 triple VLAN variant
      next_st.tri_idx = (i_next_key_kind == KEY_TRI_VLAN)
        && i_triple_vlan_key_choice[i_lookup_idx];
      // R18 skip then step
      next_st.frame_ptr = step_ptr;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_valid = st.valid;
  assign o_policy_group = st.policy_group;
  assign o_entry_match_tag = st.match_tag;
  assign o_header_classify_result = st.match_tag;
  assign o_cpu_tag_valid = st.cpu_tag_valid;
  assign o_logical_port = st.logical_port;
  assign o_header_source_port = st.src_port;
  assign o_pipeline_point = st.point;
  assign o_pipeline_action = st.action;
  assign o_next_key_kind = st.key_kind;
  assign o_tri_vlan_indexed = st.tri_idx;
  assign o_key_dst_swap = st.dst_swap;
  assign o_lookups_finished = st.finished;
  assign o_frame_pointer = st.frame_ptr;
  assign o_custom_key_sel = st.custom_sel;
  assign o_custom_first_en = st.custom_first;
  assign o_custom_second_en = st.custom_second;
  assign o_custom_extract_ptr = st.ext_ptr;
  assign o_custom_extract_valid = st.ext_valid;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_pag_merge;
    i_act_valid && !i_first_lookup && !i_act_reduced |=> o_policy_group ==
      (($past(i_policy_group_prev) & ~$past(i_policy_group_override_mask))
      | ($past(i_policy_group_value) & $past(i_policy_group_override_mask)));
  endproperty
  a_pag_merge: assert property (p_pag_merge) else $error("policy group merge wrong"); // R3

  property p_logical_port;
    i_act_valid && !i_act_reduced && i_logical_port_override_en |=>
      o_logical_port == $past(i_logical_port_value)
      && o_header_source_port == $past(i_logical_port_value);
  endproperty
  a_logical_port: assert property (p_logical_port) else $error("logical port not overridden"); // R5

  property p_tag;
    i_act_valid && i_act_reduced |=> o_header_classify_result == $past(i_match_tag_prev);
  endproperty
  a_tag: assert property (p_tag) else $error("reduced form changed match tag"); // R20

  property p_cpu;
    i_act_valid && i_to_cpu |=> o_cpu_tag_valid && o_valid;
  endproperty
  a_cpu: assert property (p_cpu) else $error("processor tag missing"); // R6

  property p_tag_merge;
    i_act_valid && !i_act_reduced |=> o_header_classify_result ==
      (($past(i_match_tag_prev) & ~$past(i_entry_match_tag_mask))
      | ($past(i_entry_match_tag) & $past(i_entry_match_tag_mask)));
  endproperty
  a_tag_merge: assert property (p_tag_merge) else $error("match tag merge wrong"); // R7

  property p_done;
    i_act_valid && i_next_key_kind == KEY_FINISHED |=> o_lookups_finished && !o_key_dst_swap;
  endproperty
  a_done: assert property (p_done) else $error("lookups not finished"); // R12

  property p_step;
    i_act_valid && !i_act_reduced && i_next_pointer_layer_skip == LSKIP_NONE |=>
      o_frame_pointer == 8'($past(i_frame_ptr) + {$past(i_next_pointer_pair_step), 1'b0});
  endproperty
  a_step: assert property (p_step) else $error("pair step advance wrong"); // R16

  property p_keep;
    i_act_valid && i_pipeline_force_code == FORCE_NONE |=>
      o_pipeline_action == $past(i_pipeline_action_prev)
      && o_pipeline_point == $past(i_pipeline_point_prev);
  endproperty
  a_keep: assert property (p_keep) else $error("pipeline changed without force"); // R8

  property p_eth_only;
    i_act_valid && !i_act_reduced && i_custom_extract_point == EXT_CURRENT && !is_eth
      |=> !o_custom_extract_valid;
  endproperty
  a_eth_only: assert property (p_eth_only) else $error("current point on non Ethernet"); // R19

  property p_custom;
    i_act_valid && !i_act_reduced |=> o_custom_key_sel == $past(i_custom_rule_select[SEL_BIT])
      && o_custom_second_en == $past(i_custom_rule_select[SECOND_BIT]);
  endproperty
  a_custom: assert property (p_custom) else $error("custom key selection wrong"); // R1

  c_force: cover property (i_act_valid && i_pipeline_force_code == FORCE_LOOPBACK);
  c_finish: cover property (i_act_valid ##1 o_lookups_finished);
  c_first: cover property (i_act_valid && i_first_lookup && i_pag_cfg_we);
endmodule // cla_apply

// ### tb/cla_result_sink.sv
// Purpose: Downstream stage model that takes each applied result.
// Assumes: A result is offered for one cycle together with the valid pulse.
// Notes: Counts results so that a lost or doubled pulse shows up at the end.
`timescale 1ns/1ns
module cla_result_sink
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_valid,
  input wire logic [7:0] i_frame_pointer,
  output logic [15:0] o_taken,
  output logic [7:0] o_last_pointer
);
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_taken <= 16'h0000;
      o_last_pointer <= 8'h00;
    end
    else if (i_valid)
    begin
      o_taken <= o_taken + 16'h0001;
      o_last_pointer <= i_frame_pointer;
    end
  end
endmodule // cla_result_sink

// ### tb/cla_apply_bench.sv
// Purpose: Self-checking bench for the classifier action apply block.
// Assumes: Inputs change on the falling edge; results are read on the following falling edge.
// Notes: Actions are spaced by one idle cycle so each valid pulse is seen alone.
`timescale 1ns/1ns
module cla_apply_bench
  import cla_pkg::*;
;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_pag_cfg_we = 1'b0, i_act_valid = 1'b0;
  logic i_act_reduced = 1'b0, i_first_lookup = 1'b0, i_frame_is_ip = 1'b0, i_to_cpu = 1'b0;
  logic i_logical_port_override_en = 1'b0, i_pipeline_action_variant = 1'b0;
  logic [5:0] i_pag_cfg_port = 6'h00, i_ingress_port = 6'h00;
  logic [5:0] i_logical_port_prev = 6'h00, i_logical_port_value = 6'h00;
  logic [7:0] i_pag_cfg_value = 8'h00, i_policy_group_prev = 8'h00, i_frame_ptr = 8'h00;
  logic [7:0] i_l2_payload_ptr = 8'h00, i_eth_end_ptr = 8'h00, i_ip_end_ptr = 8'h00;
  logic [7:0] i_policy_group_override_mask = 8'h00, i_policy_group_value = 8'h00;
  logic [11:0] i_match_tag_prev = 12'h000, i_entry_match_tag = 12'h000;
  logic [11:0] i_entry_match_tag_mask = 12'h000;
  logic [3:0] i_triple_vlan_key_choice = 4'h0, i_next_key_kind = 4'h0;
  logic [1:0] i_lookup_idx = 2'h0, i_frame_type = 2'h0, i_custom_extract_point = 2'h0;
  logic [1:0] i_pipeline_force_code = 2'h0, i_next_pointer_quad_step = 2'h0;
  logic [1:0] i_next_pointer_layer_skip = 2'h0;
  logic [4:0] i_pipeline_point_prev = 5'h00, i_pipeline_point = 5'h00;
  logic [4:0] i_next_pointer_pair_step = 5'h00;
  logic [2:0] i_pipeline_action_prev = 3'h0, i_custom_rule_select = 3'h0;
  logic [2:0] i_pipeline_point_short = 3'h0;
  logic o_valid, o_cpu_tag_valid, o_tri_vlan_indexed, o_key_dst_swap, o_lookups_finished;
  logic o_custom_key_sel, o_custom_first_en, o_custom_second_en, o_custom_extract_valid;
  logic [7:0] o_policy_group, o_frame_pointer, o_custom_extract_ptr, last_ptr;
  logic [11:0] o_entry_match_tag, o_header_classify_result;
  logic [5:0] o_logical_port, o_header_source_port;
  logic [4:0] o_pipeline_point;
  logic [2:0] o_pipeline_action;
  logic [3:0] o_next_key_kind;
  logic [15:0] taken;
  logic [4:0] smap [8] = '{5'h04, 5'h06, 5'h0E, 5'h02, 5'h09, 5'h0B, 5'h10, 5'h11};
  logic [2:0] atab [8] = '{3'h6, 3'h1, 3'h2, 3'h4, 3'h6, 3'h1, 3'h3, 3'h5};
  logic [7:0] ptab [8] = '{8'h4E, 8'h5E, 8'h7E, 8'h4E, 8'h4E, 8'h4E, 8'h7E, 8'h4E};
  logic [7:0] etab [4] = '{8'h10, 8'h30, 8'h44, 8'h58};
  int compares = 0;
  int miscompares = 0;
  int n_act = 0;

  cla_apply i_dut (.i_clk, .i_resetn, .i_pag_cfg_we, .i_pag_cfg_port, .i_pag_cfg_value,
    .i_triple_vlan_key_choice, .i_act_valid, .i_act_reduced, .i_first_lookup, .i_lookup_idx,
    .i_ingress_port, .i_policy_group_prev, .i_match_tag_prev, .i_logical_port_prev,
    .i_pipeline_point_prev, .i_pipeline_action_prev, .i_frame_type, .i_frame_ptr,
    .i_l2_payload_ptr, .i_eth_end_ptr, .i_ip_end_ptr, .i_frame_is_ip, .i_to_cpu,
    .i_custom_rule_select, .i_custom_extract_point, .i_policy_group_override_mask,
    .i_policy_group_value, .i_logical_port_override_en, .i_logical_port_value,
    .i_entry_match_tag, .i_entry_match_tag_mask, .i_pipeline_force_code,
    .i_pipeline_action_variant, .i_pipeline_point, .i_pipeline_point_short, .i_next_key_kind,
    .i_next_pointer_quad_step, .i_next_pointer_pair_step, .i_next_pointer_layer_skip,
    .o_valid, .o_policy_group, .o_entry_match_tag, .o_header_classify_result,
    .o_cpu_tag_valid, .o_logical_port, .o_header_source_port, .o_pipeline_point,
    .o_pipeline_action, .o_next_key_kind, .o_tri_vlan_indexed, .o_key_dst_swap,
    .o_lookups_finished, .o_frame_pointer, .o_custom_key_sel, .o_custom_first_en,
    .o_custom_second_en, .o_custom_extract_ptr, .o_custom_extract_valid);

  cla_result_sink i_sink (.i_clk, .i_resetn, .i_valid(o_valid), .i_frame_pointer(o_frame_pointer),
    .o_taken(taken), .o_last_pointer(last_ptr));

  always #5 i_clk = ~i_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One action: an idle cycle first, so the strobe never drops and rises in one step.
  task automatic act();
    @(negedge i_clk);
    i_act_valid = 1'b1;
    n_act++;
    @(posedge i_clk);
    @(negedge i_clk);
    i_act_valid = 1'b0;
    chk(o_valid, 1'b1);
  endtask

  task automatic cfg(input logic [5:0] port, input logic [7:0] value);
    @(negedge i_clk);
    i_pag_cfg_we = 1'b1;
    i_pag_cfg_port = port;
    i_pag_cfg_value = value;
    @(posedge i_clk);
    @(negedge i_clk);
    i_pag_cfg_we = 1'b0;
  endtask

  initial
  begin
    #50000;
    miscompares++;
    give_verdict();
  end

  initial
  begin
    repeat (20) @(negedge i_clk);
    chk(o_valid, 1'b0);
    chk(o_policy_group, 8'h00);
    chk(o_frame_pointer, 8'h00);
    i_resetn = 1'b1;
    @(negedge i_clk);
    cfg(6'h05, 8'hA5);
    cfg(6'h06, 8'hFF);
    i_ingress_port = 6'h05;
    i_first_lookup = 1'b1;
    i_policy_group_prev = 8'hFF;
    i_policy_group_override_mask = 8'h0F;
    i_policy_group_value = 8'h3C;
    act();
    chk(o_policy_group, 8'hAC);
    i_first_lookup = 1'b0;
    i_policy_group_prev = 8'h55;
    i_match_tag_prev = 12'hABC;
    i_entry_match_tag = 12'h123;
    i_entry_match_tag_mask = 12'h0F0;
    i_to_cpu = 1'b1;
    i_logical_port_prev = 6'h11;
    i_logical_port_override_en = 1'b1;
    i_logical_port_value = 6'h2A;
    act();
    chk(o_policy_group, 8'h5C);
    chk(o_entry_match_tag, 12'hA2C);
    chk(o_header_classify_result, 12'hA2C);
    chk(o_cpu_tag_valid, 1'b1);
    chk(o_logical_port, 6'h2A);
    chk(o_header_source_port, 6'h2A);
    i_logical_port_override_en = 1'b0;
    i_to_cpu = 1'b0;
    act();
    chk(o_logical_port, 6'h11);
    chk(o_cpu_tag_valid, 1'b0);
    i_pipeline_point_prev = 5'h03;
    i_pipeline_action_prev = 3'h6;
    i_pipeline_point = PT_DONE;
    for (int c = 0; c < 8; c++)
    begin
      i_pipeline_force_code = c[1:0];
      i_pipeline_action_variant = c[2];
      act();
      chk(o_pipeline_action, atab[c]);
      chk(o_pipeline_point, (c[1:0] == 2'h0) ? 5'h03 : PT_DONE);
    end
    // Reduced form: masks and override are set but must have no effect.
    i_act_reduced = 1'b1;
    i_pipeline_force_code = FORCE_EXTRACT;
    i_logical_port_override_en = 1'b1;
    i_policy_group_override_mask = 8'hFF;
    i_entry_match_tag_mask = 12'hFFF;
    i_frame_ptr = 8'h10;
    i_next_pointer_quad_step = 2'h3;
    i_next_pointer_pair_step = 5'h1F;
    for (int c = 0; c < 8; c++)
    begin
      i_pipeline_point_short = c[2:0];
      act();
      chk(o_pipeline_point, smap[c]);
    end
    chk(o_policy_group, 8'h55);
    chk(o_logical_port, 6'h11);
    chk(o_entry_match_tag, 12'hABC);
    chk(o_frame_pointer, 8'h1C);
    i_act_reduced = 1'b0;
    i_eth_end_ptr = 8'h20;
    i_ip_end_ptr = 8'h40;
    i_frame_is_ip = 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      i_frame_type = {1'b0, c[2]};
      i_next_pointer_layer_skip = c[1:0];
      act();
      chk(o_frame_pointer, ptab[c]);
    end
    i_triple_vlan_key_choice = 4'h4;
    i_lookup_idx = 2'h2;
    for (int k = 0; k < 16; k++)
    begin
      i_next_key_kind = k[3:0];
      act();
      chk(o_next_key_kind, k[3:0]);
      chk(o_lookups_finished, k == 15);
      chk(o_key_dst_swap, k == 8);
    end
    i_next_key_kind = KEY_TRI_VLAN;
    act();
    chk(o_tri_vlan_indexed, 1'b1);
    i_lookup_idx = 2'h1;
    act();
    chk(o_tri_vlan_indexed, 1'b0);
    i_frame_type = ETHERNET_LAYER_TYPE;
    i_l2_payload_ptr = 8'h30;
    i_custom_rule_select = 3'h5;
    for (int c = 0; c < 4; c++)
    begin
      i_custom_extract_point = c[1:0];
      act();
      chk(o_custom_extract_ptr, etab[c]);
      chk(o_custom_extract_valid, 1'b1);
    end
    chk(o_custom_key_sel, 1'b1);
    chk(o_custom_first_en, 1'b0);
    chk(o_custom_second_en, 1'b1);
    i_frame_type = 2'h1;
    i_custom_extract_point = EXT_CURRENT;
    i_custom_rule_select = 3'h2;
    act();
    chk(o_custom_extract_valid, 1'b0);
    chk(o_custom_key_sel, 1'b0);
    chk(o_custom_first_en, 1'b1);
    @(negedge i_clk);
    chk(o_valid, 1'b0);
    chk(taken, n_act[15:0]);
    chk(last_ptr, 8'h4E);
    // A reset in mid-run must clear the per-port default table.
    i_resetn = 1'b0;
    @(negedge i_clk);
    i_resetn = 1'b1;
    i_first_lookup = 1'b1;
    i_policy_group_override_mask = 8'h00;
    act();
    chk(o_policy_group, 8'h00);
    give_verdict();
  end
endmodule // cla_apply_bench
